// ---- rtl/wtc_pkg.sv ----
// Constants and types shared by the timed-configuration watchdog
// Summary of operation
// R01 - Change-enable clears itself after four clocks
// R02 - Enable write one starts, zero stops
// R03 - Enable clear ignored unless change-enable set
// R04 - Software disables via two-write four-cycle sequence
// R05 - Higher safety level never allows disabling
// R06 - Prescaler selects 16K to 2048K oscillator cycles
// R07 - Prescaler code 011 selects 128K cycles
// R08 - Prescaler changes only inside timed sequence
// R09 - Lower level: reset disabled, plain enable
// R10 - Lower level: open sequence, then write values
// R11 - Higher level: always runs, enable reads one
// R12 - Higher level: open with change-enable and enable; the code opens the sequence on change-enable alone at either level
// R13 - Higher level: enable value in second write ignored
// R14 - Control resets to zero, top bits read zero
// R15 - Counter runs from separate one-megahertz oscillator; the code derives a one-megahertz tick from the system clock
// R16 - Counter cleared by restart, disable, reset
// R17 - Expiry issues one-clock reset pulse
// R18 - Fuse selects safety level and initial state
package wtc_pkg;

	// Register map
	localparam logic [7:0] WTC_CTRL_OFFSET = 8'h00;
	localparam logic [7:0] WTC_CTRL_RESET = 8'h00;

	// Control field positions
	localparam int CE_POS = 4;
	localparam int EN_POS = 3;
	localparam int SEL_MSB = 2;
	localparam int SEL_LSB = 0;
	localparam int SEL_W = SEL_MSB - SEL_LSB + 1;

	// Clock rates and derived oscillator divider
	localparam int unsigned CLK_FREQ_HZ = 200_000_000;
	localparam int unsigned OSC_FREQ_HZ = 1_000_000;
	localparam int unsigned OSC_DIV = CLK_FREQ_HZ / OSC_FREQ_HZ;
	localparam int DIV_W = 8;

	// Sequence window in system clock cycles
	localparam int unsigned CE_WINDOW_CYC = 4;
	localparam int CE_CNT_W = 2;

	// Shortest time-out in oscillator cycles (16K)
	localparam int unsigned TMO_BASE_OSC = 16384;
	localparam int CNT_W = 21;

	// Safety levels chosen by the always-on fuse
	typedef enum logic
	{
		WTC_LEVEL1 = 1'b0,
		WTC_LEVEL2 = 1'b1
	} wtc_level_e;

endpackage

// ---- rtl/wtc_osc_tick.sv ----
// Watchdog oscillator stand-in: one tick per oscillator period
module wtc_osc_tick
	import wtc_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	output logic tick_o
);

	logic [DIV_W-1:0] div_r;
	logic [DIV_W-1:0] div_nxt;
	logic tick_r;
	logic tick_nxt;

	// Divide the system clock down to the oscillator rate
	always_comb
	begin
		div_nxt = div_r + DIV_W'(1);
		tick_nxt = 1'b0;
		if (div_r == DIV_W'(OSC_DIV - 1)) // R15
		begin
			div_nxt = '0;
			tick_nxt = 1'b1;
		end
	end

	// Divider state
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			div_r <= '0;
			tick_r <= 1'b0;
		end
		else
		begin
			div_r <= div_nxt;
			tick_r <= tick_nxt;
		end
	end

	assign tick_o = tick_r;

endmodule // wtc_osc_tick

// ---- rtl/wtc_timeout_ctr.sv ----
// Time-out counter in oscillator ticks with selectable period
module wtc_timeout_ctr
	import wtc_pkg::*;
#(
	parameter int unsigned TMO_BASE = TMO_BASE_OSC
)
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic tick_i,
	input wire logic run_i,
	input wire logic clear_i,
	input wire logic [SEL_W-1:0] sel_i,
	output logic expire_o
);

	logic [CNT_W-1:0] cnt_r;
	logic [CNT_W-1:0] cnt_nxt;
	logic expire_r;
	logic expire_nxt;
	logic [31:0] span;
	logic [CNT_W-1:0] term;

	// Period doubles per code step; 011 lands on 128K
	assign span = 32'(TMO_BASE) << sel_i; // R06 R07
	assign term = CNT_W'(span - 32'h1);

	// Count ticks; clear on restart or while stopped
	always_comb
	begin
		cnt_nxt = cnt_r;
		expire_nxt = 1'b0;
		if (clear_i || !run_i) // R16
		begin
			cnt_nxt = '0;
		end
		else if (tick_i)
		begin
			if (cnt_r >= term)
			begin
				cnt_nxt = '0;
				expire_nxt = 1'b1; // R17
			end
			else
			begin
				cnt_nxt = cnt_r + CNT_W'(1);
			end
		end
	end

	// Counter state
	always_ff @(posedge clk_i)
	begin
		if (rst_i) // R16
		begin
			cnt_r <= '0;
			expire_r <= 1'b0;
		end
		else
		begin
			cnt_r <= cnt_nxt;
			expire_r <= expire_nxt;
		end
	end

	assign expire_o = expire_r;

endmodule // wtc_timeout_ctr

// ---- rtl/wtc_top.sv ----
// Watchdog with timed configuration sequence and Wishbone slave
//
// The Wishbone register port and the placing of the registers were decided locally.
module wtc_top
	import wtc_pkg::*;
#(
	parameter int unsigned TMO_BASE = TMO_BASE_OSC
)
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic restart_instruction_i,
	input wire logic always_on_fuse_i,
	output logic expiry_reset_o
);

	// Bus slave state
	logic ack_r;
	logic ack_nxt;
	logic [31:0] rdat_r;
	logic [31:0] rdat_nxt;

	// Control register state
	logic ce_r;
	logic ce_nxt;
	logic en_r;
	logic en_nxt;
	logic [SEL_W-1:0] sel_r;
	logic [SEL_W-1:0] sel_nxt;
	logic [CE_CNT_W-1:0] win_r;
	logic [CE_CNT_W-1:0] win_nxt;

	// Safety level caught while reset is held
	wtc_level_e level_r;
	wtc_level_e level_nxt;

	logic req;
	logic hit;
	logic wr_acc;
	logic wr_ce;
	logic wr_en;
	logic [SEL_W-1:0] wr_sel;
	logic level2;
	logic en_eff;
	logic [7:0] ctrl_view;
	logic tick;
	logic expire;

	// Request decode; only byte lane 0 carries the register
	assign req = wb_cyc_i && wb_stb_i;
	assign hit = (wb_adr_i == WTC_CTRL_OFFSET);
	assign wr_acc = req && ack_r && wb_we_i && hit && wb_sel_i[0];
	assign wr_ce = wb_dat_i[CE_POS];
	assign wr_en = wb_dat_i[EN_POS];
	assign wr_sel = wb_dat_i[SEL_MSB:SEL_LSB];

	// Level 2 forces the watchdog on whatever was written
	assign level2 = (level_r == WTC_LEVEL2);
	assign en_eff = en_r || level2; // R11 R18

	// Read view; bits 7..5 are fixed zero
	always_comb
	begin
		ctrl_view = WTC_CTRL_RESET; // R14
		ctrl_view[CE_POS] = ce_r;
		ctrl_view[EN_POS] = en_eff; // R11
		ctrl_view[SEL_MSB:SEL_LSB] = sel_r;
	end

	// Ack one cycle after the request, then drop for a cycle
	always_comb
	begin
		ack_nxt = req && !ack_r;
		rdat_nxt = rdat_r;
		if (req && !ack_r)
		begin
			rdat_nxt = hit ? {24'h000000, ctrl_view} : 32'h00000000;
		end
	end

	// Bus slave registers
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ack_r <= 1'b0;
			rdat_r <= 32'h00000000;
		end
		else
		begin
			ack_r <= ack_nxt;
			rdat_r <= rdat_nxt;
		end
	end

	assign wb_ack_o = ack_r;
	assign wb_dat_o = rdat_r;

	// Control register next state; a write beats the self-clear
	always_comb
	begin
		ce_nxt = ce_r;
		en_nxt = en_r;
		sel_nxt = sel_r;
		win_nxt = win_r;
		if (ce_r)
		begin
			if (win_r == '0)
			begin
				ce_nxt = 1'b0; // R01
			end
			else
			begin
				win_nxt = win_r - CE_CNT_W'(1);
			end
		end
		if (wr_acc)
		begin
			if (ce_r)
			begin
				// Sequence open: new period always taken
				sel_nxt = wr_sel; // R08 R10 R13
				if (!level2)
				begin
					en_nxt = wr_en; // R02 R04 R10
				end
				// Enable value is irrelevant at level 2
				else
				begin
					en_nxt = en_r; // R05 R13
				end
			end
			else
			begin
				// Closed: enable may only be set, period kept
				en_nxt = en_r || wr_en; // R02 R03 R09
				sel_nxt = sel_r; // R08
			end
			if (wr_ce)
			begin
				// Opening write; re-arming restarts the window
				ce_nxt = 1'b1; // R12
				win_nxt = CE_CNT_W'(CE_WINDOW_CYC - 1); // R01
			end
			else
			begin
				ce_nxt = 1'b0;
				win_nxt = '0;
			end
		end
	end

	// Level follows the fuse during reset, then stays put
	always_comb
	begin
		level_nxt = level_r;
		if (rst_i)
		begin
			level_nxt = always_on_fuse_i ? WTC_LEVEL2 : WTC_LEVEL1; // R18
		end
	end

	// Control registers; the fuse level is sampled through reset
	always_ff @(posedge clk_i)
	begin
		level_r <= level_nxt;
		if (rst_i)
		begin
			ce_r <= WTC_CTRL_RESET[CE_POS]; // R14
			en_r <= WTC_CTRL_RESET[EN_POS]; // R09
			sel_r <= WTC_CTRL_RESET[SEL_MSB:SEL_LSB];
			win_r <= '0;
		end
		else
		begin
			ce_r <= ce_nxt;
			en_r <= en_nxt;
			sel_r <= sel_nxt;
			win_r <= win_nxt;
		end
	end

	// Oscillator tick derived from the system clock
	wtc_osc_tick i_wtc_osc_tick
	(
		.clk_i (clk_i),
		.rst_i (rst_i),
		.tick_o (tick)
	);

	// Time-out counter; disable and restart both clear it
	wtc_timeout_ctr #(
		.TMO_BASE (TMO_BASE)
	) i_wtc_timeout_ctr
	(
		.clk_i (clk_i),
		.rst_i (rst_i),
		.tick_i (tick),
		.run_i (en_eff),
		.clear_i (restart_instruction_i), // R16
		.sel_i (sel_r),
		.expire_o (expire)
	);

	// Expiry pulse is already a single registered cycle
	assign expiry_reset_o = expire; // R17

	// Checks on the control sequence and outputs
	sequence s_ce_open;
		wr_acc && wr_ce;
	endsequence

	sequence s_ce_quiet;
		s_ce_open ##1 (ce_r && !wr_acc)[*4];
	endsequence

	property p_ce_set;
		@(posedge clk_i) disable iff (rst_i)
		s_ce_open |=> ce_r;
	endproperty
	a_ce_set: assert property (p_ce_set) // R01
		else $error("change enable not set by write");

	property p_ce_clear;
		@(posedge clk_i) disable iff (rst_i)
		s_ce_quiet |=> !ce_r;
	endproperty
	a_ce_clear: assert property (p_ce_clear) // R01
		else $error("change enable not cleared after four cycles");

	property p_en_start;
		@(posedge clk_i) disable iff (rst_i)
		wr_acc && wr_en |=> en_eff;
	endproperty
	a_en_start: assert property (p_en_start) // R02
		else $error("enable write did not start watchdog");

	property p_no_clear_closed;
		@(posedge clk_i) disable iff (rst_i)
		wr_acc && !ce_r && en_eff |=> en_eff;
	endproperty
	a_no_clear_closed: assert property (p_no_clear_closed) // R03
		else $error("enable cleared without change enable");

	property p_disable;
		@(posedge clk_i) disable iff (rst_i)
		wr_acc && ce_r && !wr_en && !wr_ce && !level2 |=> !en_eff;
	endproperty
	a_disable: assert property (p_disable) // R02
		else $error("timed sequence did not disable watchdog");

	property p_level2_on;
		@(posedge clk_i) disable iff (rst_i)
		level2 && wb_ack_o && !wb_we_i && hit |-> wb_dat_o[EN_POS];
	endproperty
	a_level2_on: assert property (p_level2_on) // R11
		else $error("level 2 enable did not read as one");

	property p_level2_keep;
		@(posedge clk_i) disable iff (rst_i)
		level2 ##1 level2 |-> en_eff;
	endproperty
	a_level2_keep: assert property (p_level2_keep) // R05
		else $error("level 2 watchdog stopped");

	property p_sel_locked;
		@(posedge clk_i) disable iff (rst_i)
		wr_acc && !ce_r |=> $stable(sel_r);
	endproperty
	a_sel_locked: assert property (p_sel_locked) // R08
		else $error("prescaler changed outside sequence");

	property p_sel_open;
		@(posedge clk_i) disable iff (rst_i)
		wr_acc && ce_r |=> sel_r == $past(wr_sel);
	endproperty
	a_sel_open: assert property (p_sel_open) // R13
		else $error("prescaler not taken inside sequence");

	property p_reset_pulse;
		@(posedge clk_i) disable iff (rst_i)
		$rose(expiry_reset_o) |=> !expiry_reset_o;
	endproperty
	a_reset_pulse: assert property (p_reset_pulse) // R17
		else $error("watchdog reset pulse longer than one cycle");

	property p_off_silent;
		@(posedge clk_i) disable iff (rst_i)
		!en_eff ##1 !en_eff |-> !expiry_reset_o;
	endproperty
	a_off_silent: assert property (p_off_silent) // R16
		else $error("reset pulse while watchdog disabled");

	property p_reg_reset;
		@(posedge clk_i) disable iff (rst_i)
		$past(rst_i) |-> !ce_r && !en_r && sel_r == '0;
	endproperty
	a_reg_reset: assert property (p_reg_reset) // R14
		else $error("control register not zero after reset");

	property p_ack_pulse;
		@(posedge clk_i) disable iff (rst_i)
		wb_ack_o |=> !wb_ack_o;
	endproperty
	a_ack_pulse: assert property (p_ack_pulse)
		else $error("ack held for more than one cycle");

endmodule // wtc_top

// ---- verif/wtc_top_tb_top.sv ----
// Self-checking bench for the timed-configuration watchdog
module wtc_top_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import wtc_pkg::*;

	localparam int unsigned TB_BASE = 4;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [3:0] sel = 4'h1;
	logic [31:0] dat = 32'h0;
	logic [31:0] wb_dat_o;
	logic wb_ack_o;
	logic kick = 1'b0;
	logic fuse = 1'b0;
	logic expiry_reset_o;
	int n_mismatch = 0;
	int checked = 0;

	// Short base count keeps each expiry under a few thousand clocks
	wtc_top #(.TMO_BASE(TB_BASE)) i_wtc_top (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.wb_cyc_i(cyc),
		.wb_stb_i(stb),
		.wb_we_i(we),
		.wb_adr_i(adr),
		.wb_sel_i(sel),
		.wb_dat_i(dat),
		.wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o),
		.restart_instruction_i(kick),
		.always_on_fuse_i(fuse),
		.expiry_reset_o(expiry_reset_o)
	);

	// 200 MHz system clock
	initial
	begin
		forever #2.5 clk_i = ~clk_i;
	end

	task automatic conclude();
		$display("Comparisons %0d, mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic chk(input string name, input logic [31:0] exp,
		input logic [31:0] got);
		checked++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", name, exp, got);
		end
	endtask

	// Classic single cycle; held until ack is sampled high
	task automatic wb(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q);
		int n;
		n = 0;
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		do
		begin
			@(posedge clk_i);
			n++;
		end
		while (wb_ack_o !== 1'b1);
		q = wb_dat_o;
		// Slave answers one cycle after the request is seen
		chk("ack_latency", 32'h2, 32'(n));
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [31:0] q;
		wb(1'b1, a, {24'h0, d}, q);
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
		logic [31:0] q;
		wb(1'b0, a, 32'h0, q);
		chk("read", {24'h0, e}, q);
	endtask

	task automatic do_reset(input logic f);
		@(posedge clk_i);
		rst_i <= 1'b1;
		fuse <= f;
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b0;
	endtask

	// Expiry must land inside the window and last one clock
	task automatic wait_exp(input int lo, input int hi);
		int n;
		n = 0;
		while (expiry_reset_o !== 1'b1 && n < hi)
		begin
			@(posedge clk_i);
			n++;
		end
		chk("expiry_in_window", 32'h1, 32'(n >= lo && n < hi));
		@(posedge clk_i);
		chk("pulse_width", 32'h0, 32'(expiry_reset_o));
	endtask

	// Counts expiry pulses over a span, kicking the restart if asked
	task automatic quiet(input int span, input logic k);
		int p;
		p = 0;
		// Restart held for the whole span, dropped once at the end
		kick <= k;
		repeat (span)
		begin
			@(posedge clk_i);
			if (expiry_reset_o !== 1'b0)
				p++;
		end
		kick <= 1'b0;
		chk("no_expiry", 32'h0, 32'(p));
	endtask

	task automatic t_reset_vals();
		rd_chk(8'h00, 8'h00);
		wr(8'h04, 8'h08);
		rd_chk(8'h04, 8'h00);
		rd_chk(8'h00, 8'h00);
		quiet(1000, 1'b0);
	endtask

	task automatic t_enable();
		// Plain enable with top bits set; change-enable left clear
		wr(8'h00, 8'he8);
		rd_chk(8'h00, 8'h08);
		wr(8'h00, 8'h00);
		rd_chk(8'h00, 8'h08);
	endtask

	task automatic t_timed();
		wr(8'h00, 8'h18);
		repeat (6) @(posedge clk_i);
		rd_chk(8'h00, 8'h08);
		wr(8'h00, 8'h18);
		wr(8'h00, 8'h01);
		rd_chk(8'h00, 8'h01);
		wr(8'h00, 8'h0a);
		rd_chk(8'h00, 8'h09);
	endtask

	task automatic t_expiry();
		// Eight ticks of 200 clocks, tick phase unknown
		wait_exp(7 * 200 - 20, 8 * 200 + 20);
		quiet(2500, 1'b1);
		wr(8'h00, 8'h18);
		wr(8'h00, 8'h00);
		rd_chk(8'h00, 8'h00);
		quiet(2500, 1'b0);
	endtask

	task automatic t_level2();
		do_reset(1'b1);
		rd_chk(8'h00, 8'h08);
		wait_exp(3 * 200 - 20, 4 * 200 + 20);
		wr(8'h00, 8'h00);
		rd_chk(8'h00, 8'h08);
		wr(8'h00, 8'h18);
		wr(8'h00, 8'h03);
		rd_chk(8'h00, 8'h0b);
		wr(8'h00, 8'h02);
		rd_chk(8'h00, 8'h0b);
		// Code 011: restart once, then 32 ticks of 200 clocks
		quiet(1, 1'b1);
		wait_exp(31 * 200 - 20, 32 * 200 + 20);
	endtask

	// Main sequence
	initial
	begin
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b0;
		t_reset_vals();
		t_enable();
		t_timed();
		t_expiry();
		t_level2();
		conclude();
	end

	// Watchdog for a hung bench, well beyond the expected run
	initial
	begin
		repeat (60000) @(posedge clk_i);
		n_mismatch++;
		conclude();
	end
endmodule // wtc_top_tb_top
